// ---- bench/toa_link_assertions.sv ----
// Protocol checks on the link between the controller and base station ends
`timescale 1ns/10ps
module toa_link_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic setup_valid,
  input wire logic signed [toa_pkg::TOA_W-1:0] window_start_offset,
  input wire logic signed [toa_pkg::TOA_W-1:0] window_end_offset,
  input wire logic dl_valid,
  input wire toa_pkg::dl_kind_e dl_kind,
  input wire logic [toa_pkg::CFN_W-1:0] dl_cfn,
  input wire logic ho_valid,
  input wire logic [toa_pkg::CFN_W-1:0] ho_frame_offset,
  input wire logic [toa_pkg::CHIP_W-1:0] ho_chip_offset,
  input wire logic ul_valid,
  input wire toa_pkg::ul_kind_e ul_kind,
  input wire logic [toa_pkg::CFN_W-1:0] ul_cfn,
  input wire logic signed [toa_pkg::TOA_W-1:0] ul_toa
);
  import toa_pkg::*;
  logic signed [TOA_W-1:0] win_s_reg;
  logic signed [TOA_W-1:0] win_e_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the window as the device latches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_s_reg <= TOA_ZERO;
      win_e_reg <= TOA_ZERO;
    end else if (setup_valid) begin
      win_s_reg <= window_start_offset;
      win_e_reg <= window_end_offset;
    end
  end
  a_sync_answer: assert property (dl_valid && dl_kind == DL_SYNC |=> ul_valid && ul_kind == UL_SYNC_REPLY)
    else $error("sync frame not answered next cycle");
  a_reply_cause: assert property (ul_valid |->
    $past(dl_valid) && ((ul_kind == UL_SYNC_REPLY) == ($past(dl_kind) == DL_SYNC)))
    else $error("reply without matching downlink frame");
  a_reply_cfn: assert property (ul_valid |-> ul_cfn == $past(dl_cfn))
    else $error("reply frame number differs");
  a_adjust_outside: assert property (ul_valid && ul_kind == UL_TIMING_ADJ |->
    ul_toa > $past(win_s_reg) || ul_toa < $past(win_e_reg))
    else $error("timing adjust for frame inside window");
  a_toa_range: assert property (ul_valid |-> ul_toa > -HALF_SPAN && ul_toa <= HALF_SPAN)
    else $error("arrival offset outside wrap range");
  a_chip_range: assert property (ho_valid |-> ho_chip_offset < FRAME_CHIPS)
    else $error("handover chip offset beyond one frame");
  a_reply_hold: assert property (!ul_valid |-> $stable(ul_toa) && $stable(ul_cfn) && $stable(ul_kind))
    else $error("reply fields moved between replies");
  a_ho_single: assert property (ho_valid |=> !ho_valid)
    else $error("handover offsets sent twice");
  c_sync: cover property (ul_valid && ul_kind == UL_SYNC_REPLY);
  c_adjust: cover property (ul_valid && ul_kind == UL_TIMING_ADJ);
  c_ho: cover property (ho_valid);
endmodule

// ---- bench/toa_window_monitor_tb_top.sv ----
// Self-checking bench joining controller and base station ends
`timescale 1ns/10ps
module toa_window_monitor_tb_top;
  import toa_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic setup_req = 1'b0, data_req = 1'b0, sync_req = 1'b0, ho_req = 1'b0, first_link = 1'b0;
  logic peer_toa_valid = 1'b0, meas_valid = 1'b0, ref_frame_start = 1'b0;
  logic signed [TOA_W-1:0] setup_window_start = '0, setup_window_end = '0, peer_toa = '0;
  logic [CFN_W-1:0] req_cfn = '0, ho_frame = '0, meas_target_frame = '0, meas_tx_frame = '0, ref_frame_number = '0;
  logic [CHIP_W-1:0] default_dedicated_channel_skew = '0, ho_chip = '0, meas_tx_chip = '0;
  logic frame_start, data_out_valid, data_out_late, reply_valid, reply_kind, adjust_valid, adjust_advance;
  logic meas_out_valid;
  logic [CFN_W-1:0] system_frame_number, data_out_cfn, reply_cfn, meas_frame_skew;
  logic [ABS_W-1:0] downlink_dedicated_channel_offset;
  logic [CELL_COUNT-1:0] sync_burst;
  logic signed [TOA_W-1:0] reply_toa, adjust_amount;
  logic [CHIP_W-1:0] chip_remainder;
  int errors = 0, comparisons = 0, cyc = 0, tref = 0, fr, own;
  toa_link_if link();
  toa_base_station toa_base_station_inst (.link(link.device), .*);
  toa_controller toa_controller_inst (.link(link.ctrl), .*);
  toa_link_assertions toa_link_assertions_inst (.clk(clk), .rst(rst), .setup_valid(link.setup_valid),
    .window_start_offset(link.window_start_offset), .window_end_offset(link.window_end_offset),
    .dl_valid(link.dl_valid), .dl_kind(link.dl_kind), .dl_cfn(link.dl_cfn), .ho_valid(link.ho_valid),
    .ho_frame_offset(link.ho_frame_offset), .ho_chip_offset(link.ho_chip_offset), .ul_valid(link.ul_valid),
    .ul_kind(link.ul_kind), .ul_cfn(link.ul_cfn), .ul_toa(link.ul_toa));
  always #12.5 clk = ~clk;
  task automatic stop_test;
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Cycle count doubles as hang guard, run needs a few hundred
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      stop_test;
    end
  end
  always @(negedge clk) if (!rst) check(32'($onehot0(sync_burst)), 1);
  // Offset from elapsed clocks; the bench knows the frame was loaded at tref
  function automatic int exp_toa(input int connection_frame_number);
    int t;
    t = connection_frame_number * FRAME_CHIPS - LATEST_LEAD_CHIPS - (fr * FRAME_CHIPS + (cyc - tref) / CHIP_DIV);
    t = t % SPAN_CHIPS;
    if (t > HALF_SPAN) t -= SPAN_CHIPS;
    if (t <= -HALF_SPAN) t += SPAN_CHIPS;
    return t;
  endfunction
  task automatic sync_once(input int c, input int p, input bit usep);
    int e, n, low;
    @(posedge clk);
    peer_toa_valid <= usep;
    peer_toa <= TOA_W'(p);
    @(posedge clk);
    peer_toa_valid <= 1'b0;
    sync_req <= 1'b1;
    req_cfn <= CFN_W'(c);
    e = exp_toa(c);
    @(posedge clk);
    sync_req <= 1'b0;
    n = 0;
    do @(negedge clk); while (reply_valid !== 1'b1 && ++n < 8);
    check(reply_valid, 1);
    own = reply_toa;
    low = (usep && p < own) ? p : own;
    check(reply_kind, 1);
    check(reply_cfn, c & 8'hFF);
    check(32'(own - e <= 3 && e - own <= 3), 1);
    check(adjust_valid, usep && low != 0);
    if (usep && low != 0) check(adjust_advance, low < 0);
    if (usep && low != 0) check(32'(adjust_amount), 32'(low));
  endtask
  task automatic data_once(input int c, input int mode);
    int e, m, ws, we;
    logic rv, dv, lt, rk;
    logic [CFN_W-1:0] cf;
    e = exp_toa(c);
    m = 50 + $urandom % 900;
    ws = (mode == 1) ? e - m : e + 2 * m;
    we = (mode == 0) ? e - m : (mode == 1) ? e - 2 * m : e + m;
    @(posedge clk);
    setup_req <= 1'b1;
    setup_window_start <= TOA_W'(ws);
    setup_window_end <= TOA_W'(we);
    @(posedge clk);
    setup_req <= 1'b0;
    repeat (2) @(posedge clk);
    data_req <= 1'b1;
    req_cfn <= CFN_W'(c);
    @(posedge clk);
    data_req <= 1'b0;
    rv = 1'b0;
    dv = 1'b0;
    lt = 1'b0;
    rk = 1'b1;
    cf = '0;
    repeat (6) begin
      @(negedge clk);
      if (reply_valid === 1'b1) begin
        rv = 1'b1;
        rk = reply_kind;
      end
      if (data_out_valid === 1'b1) begin
        dv = 1'b1;
        lt = data_out_late;
        cf = data_out_cfn;
      end
    end
    check(rv, e > ws || e < we);
    if (rv) check(rk, 0);
    check(dv, e >= 0);
    if (dv) check(lt, e < we);
    if (dv) check(cf, c & 8'hFF);
  endtask
  task automatic ho_once(input bit fl, input int f, input int c);
    int e;
    @(posedge clk);
    ho_req <= 1'b1;
    first_link <= fl;
    ho_frame <= CFN_W'(f);
    default_dedicated_channel_skew <= CHIP_W'(c);
    ho_chip <= fl ? CHIP_ZERO : CHIP_W'(c);
    @(posedge clk);
    ho_req <= 1'b0;
    repeat (4) @(negedge clk);
    e = (fl ? 0 : f * FRAME_CHIPS) + c;
    check(downlink_dedicated_channel_offset, ((e + ROUND_HALF) / ROUND_STEP * ROUND_STEP) % SPAN_CHIPS);
  endtask
  task automatic meas_once(input int t, input int f, input int c);
    int nom, n;
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_target_frame <= CFN_W'(t);
    meas_tx_frame <= CFN_W'(f);
    meas_tx_chip <= CHIP_W'(c);
    @(posedge clk);
    meas_valid <= 1'b0;
    n = 0;
    do @(negedge clk); while (meas_out_valid !== 1'b1 && ++n < 6);
    check(meas_out_valid, 1);
    nom = (f * FRAME_CHIPS + c - NOMINAL_LEAD_CHIPS + SPAN_CHIPS) % SPAN_CHIPS;
    check(chip_remainder, (nom % FRAME_CHIPS == 0) ? 0 : FRAME_CHIPS - nom % FRAME_CHIPS);
    check(meas_frame_skew, (t - nom / FRAME_CHIPS - (nom % FRAME_CHIPS != 0) + 512) % 256);
  endtask
  initial begin
    int n;
    void'($urandom(67));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    fr = 2 + $urandom % 250;
    @(posedge clk);
    ref_frame_start <= 1'b1;
    ref_frame_number <= CFN_W'(fr);
    @(posedge clk);
    ref_frame_start <= 1'b0;
    tref = cyc;
    n = 0;
    do @(negedge clk); while (frame_start !== 1'b1 && ++n < 4);
    check(frame_start, 1);
    check(system_frame_number, fr);
    // Early, on-time and late sync frames, peer offsets of both signs
    for (int i = 0; i < 12; i++) sync_once(fr + (i % 5) - 2, int'($urandom % 6000) - 3000, i % 3 != 0);
    // Inside, early and late windows for on-time and next-frame data
    for (int i = 0; i < 6; i++) data_once(fr + i % 2, i / 2);
    // Rounding corners, frame wrap and first-link default
    ho_once(1'b0, 0, 127);
    ho_once(1'b0, 0, 128);
    ho_once(1'b0, 255, 38399);
    ho_once(1'b1, 77, 1000);
    for (int i = 0; i < 6; i++) ho_once(1'b0, $urandom % 256, $urandom % FRAME_CHIPS);
    // Remainder zero, frame borrow and random measurements
    meas_once(3, 1, 1024);
    meas_once(1, 0, 0);
    for (int i = 0; i < 6; i++) meas_once($urandom % 256, $urandom % 256, $urandom % FRAME_CHIPS);
    stop_test;
  end
endmodule

// ---- design/toa_base_station.sv ----
// Base station end: arrival window supervision, offset rounding, cell timing
`timescale 1ns/10ps
// Behaviour
// - Hold window start and end per bearer
// - Frame outside window returns timing adjustment
// - Late frames before latest point still processed
// - Controller sends sync naming target frame number
// - Every sync frame answered with arrival offset
// - Intermediate controller copies sync, forwards replies
// - Controller picks smaller offset to advance/delay
// - Handover offset sent as frame plus chip
// - Round combined offset to 256 chips
// - Default skew only for first link
// - Terminal measures skew plus remainder modulo 256
// - Remainder is time to next nominal border
// - Nominal timing is fixed lead before transmit
// - Cells skewed so sync bursts never collide
// - Align frame starts, keep low frame bits
module toa_base_station (
  input wire logic clk,
  input wire logic rst,
  toa_link_if.device link,
  input wire logic ref_frame_start,
  input wire logic [toa_pkg::CFN_W-1:0] ref_frame_number,
  output logic frame_start,
  output logic [toa_pkg::CFN_W-1:0] system_frame_number,
  output logic data_out_valid,
  output logic [toa_pkg::CFN_W-1:0] data_out_cfn,
  output logic data_out_late,
  output logic [toa_pkg::ABS_W-1:0] downlink_dedicated_channel_offset,
  output logic [toa_pkg::CELL_COUNT-1:0] sync_burst
);
  import toa_pkg::*;

  // All state sits in one packed record, registered by a single process
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [CHIP_W-1:0] chip;
    logic [CHIP_W-1:0] slot_chip;
    logic [CFN_W-1:0] frame;
    logic frame_start;
    logic signed [TOA_W-1:0] win_start;
    logic signed [TOA_W-1:0] win_end;
    logic ul_valid;
    ul_kind_e ul_kind;
    logic [CFN_W-1:0] ul_cfn;
    logic signed [TOA_W-1:0] ul_toa;
    logic data_valid;
    logic [CFN_W-1:0] data_cfn;
    logic data_late;
    logic [ABS_W-1:0] dpch_offset;
    logic [CELL_COUNT-1:0] burst;
  } bs_state_s;

  bs_state_s state_reg;
  bs_state_s state_next;
  logic [CELL_COUNT-1:0] burst_next;

  // Per-cell burst placement; the skew keeps bursts of neighbours apart
  // Limitation: only a handful of cells fit in one slot at this skew
  genvar gi;
  generate
    for (gi = 0; gi < CELL_COUNT; gi++) begin : g_cell
      localparam int SKEW = gi * CELL_SKEW_CHIPS;
      logic [CHIP_W-1:0] rel;
      always_comb begin
        if (int'(state_reg.slot_chip) >= SKEW) begin
          rel = CHIP_W'(int'(state_reg.slot_chip) - SKEW);
        end else begin
          rel = CHIP_W'(int'(state_reg.slot_chip) + SLOT_CHIPS - SKEW);
        end
      end
      assign burst_next[gi] = int'(rel) < BURST_CHIPS;
    end
  endgenerate

  // Next-state logic for timebase, window check and replies
  always_comb begin
    int now_abs;
    int toa;
    int comb_off;
    logic tick;
    now_abs = 0;
    toa = 0;
    comb_off = 0;
    tick = 1'b0;
    state_next = state_reg;
    state_next.frame_start = 1'b0;
    state_next.ul_valid = 1'b0;
    state_next.data_valid = 1'b0;
    state_next.burst = burst_next;

    // Chip-rate enable from the system clock
    // Counting chips by enable keeps the whole block on one clock
    if (int'(state_reg.div) == CHIP_DIV - 1) begin
      state_next.div = '0;
      tick = 1'b1;
    end else begin
      state_next.div = state_reg.div + 1'b1;
    end
    if (tick) begin
      if (int'(state_reg.slot_chip) == SLOT_CHIPS - 1) begin
        state_next.slot_chip = CHIP_ZERO;
      end else begin
        state_next.slot_chip = state_reg.slot_chip + 1'b1;
      end
      if (int'(state_reg.chip) == FRAME_CHIPS - 1) begin
        state_next.chip = CHIP_ZERO;
        state_next.slot_chip = CHIP_ZERO;
        state_next.frame = state_reg.frame + 1'b1;
        state_next.frame_start = 1'b1;
      end else begin
        state_next.chip = state_reg.chip + 1'b1;
      end
    end
    // Reference pulse wins over the local wrap so cells stay aligned
    // frame alignment to reference
    if (ref_frame_start) begin
      state_next.div = '0;
      state_next.chip = CHIP_ZERO;
      state_next.slot_chip = CHIP_ZERO;
      state_next.frame = ref_frame_number;
      state_next.frame_start = 1'b1;
    end

    if (link.setup_valid) begin
      state_next.win_start = link.window_start_offset;
      state_next.win_end = link.window_end_offset;
    end

    now_abs = int'(state_reg.frame) * FRAME_CHIPS + int'(state_reg.chip);
    toa = int'(link.dl_cfn) * FRAME_CHIPS - LATEST_LEAD_CHIPS - now_abs;
    // Beyond half the frame-number span the target counts as the other side
    if (toa > HALF_SPAN) begin
      toa = toa - SPAN_CHIPS;
    end else if (toa <= -HALF_SPAN) begin
      toa = toa + SPAN_CHIPS;
    end

    // Reply fields move only with a reply, so the far end may read them late
    if (link.dl_valid) begin
      if (link.dl_kind == DL_SYNC) begin
        state_next.ul_valid = 1'b1;
        state_next.ul_kind = UL_SYNC_REPLY;
        state_next.ul_cfn = link.dl_cfn;
        state_next.ul_toa = TOA_W'(toa);
      end else begin
        // Both window bounds count as inside
        // adjustment when outside window
        if (toa > int'(state_reg.win_start) || toa < int'(state_reg.win_end)) begin
          state_next.ul_valid = 1'b1;
          state_next.ul_kind = UL_TIMING_ADJ;
          state_next.ul_cfn = link.dl_cfn;
          state_next.ul_toa = TOA_W'(toa);
        end
        // Early frames past the start are only reported, still processed
        // late margin still processed
        if (toa >= 0) begin
          state_next.data_valid = 1'b1;
          state_next.data_cfn = link.dl_cfn;
          state_next.data_late = toa < int'(state_reg.win_end);
        end
      end
    end

    // Half-step bias then truncation: ties go to the upper boundary
    // round to 256-chip boundary
    if (link.ho_valid) begin
      comb_off = int'(link.ho_frame_offset) * FRAME_CHIPS + int'(link.ho_chip_offset) + ROUND_HALF;
      comb_off = (comb_off / ROUND_STEP) * ROUND_STEP;
      if (comb_off >= SPAN_CHIPS) begin
        comb_off = comb_off - SPAN_CHIPS;
      end
      state_next.dpch_offset = ABS_W'(comb_off);
    end
  end

  // State register; all outputs come from here
  // A zero window after reset reports every frame not exactly on time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{div: '0, chip: CHIP_ZERO, slot_chip: CHIP_ZERO, frame: CFN_ZERO,
                     frame_start: 1'b0, win_start: TOA_ZERO, win_end: TOA_ZERO,
                     ul_valid: 1'b0, ul_kind: UL_TIMING_ADJ, ul_cfn: CFN_ZERO, ul_toa: TOA_ZERO,
                     data_valid: 1'b0, data_cfn: CFN_ZERO, data_late: 1'b0,
                     dpch_offset: ABS_ZERO, burst: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Link and pins read the register directly, never the next value
  assign link.ul_valid = state_reg.ul_valid;
  assign link.ul_kind = state_reg.ul_kind;
  assign link.ul_cfn = state_reg.ul_cfn;
  assign link.ul_toa = state_reg.ul_toa;
  assign frame_start = state_reg.frame_start;
  assign system_frame_number = state_reg.frame;
  assign data_out_valid = state_reg.data_valid;
  assign data_out_cfn = state_reg.data_cfn;
  assign data_out_late = state_reg.data_late;
  assign downlink_dedicated_channel_offset = state_reg.dpch_offset;
  assign sync_burst = state_reg.burst;
endmodule

// ---- design/toa_controller.sv ----
// Controller end: sync requests, reply forwarding, offset choice, handover offsets
`timescale 1ns/10ps
module toa_controller (
  input wire logic clk,
  input wire logic rst,
  toa_link_if.ctrl link,
  input wire logic setup_req,
  input wire logic signed [toa_pkg::TOA_W-1:0] setup_window_start,
  input wire logic signed [toa_pkg::TOA_W-1:0] setup_window_end,
  input wire logic data_req,
  input wire logic sync_req,
  input wire logic [toa_pkg::CFN_W-1:0] req_cfn,
  input wire logic ho_req,
  input wire logic first_link,
  input wire logic [toa_pkg::CHIP_W-1:0] default_dedicated_channel_skew,
  input wire logic [toa_pkg::CFN_W-1:0] ho_frame,
  input wire logic [toa_pkg::CHIP_W-1:0] ho_chip,
  input wire logic peer_toa_valid,
  input wire logic signed [toa_pkg::TOA_W-1:0] peer_toa,
  input wire logic meas_valid,
  input wire logic [toa_pkg::CFN_W-1:0] meas_target_frame,
  input wire logic [toa_pkg::CFN_W-1:0] meas_tx_frame,
  input wire logic [toa_pkg::CHIP_W-1:0] meas_tx_chip,
  output logic reply_valid,
  output logic reply_kind,
  output logic [toa_pkg::CFN_W-1:0] reply_cfn,
  output logic signed [toa_pkg::TOA_W-1:0] reply_toa,
  output logic adjust_valid,
  output logic adjust_advance,
  output logic signed [toa_pkg::TOA_W-1:0] adjust_amount,
  output logic meas_out_valid,
  output logic [toa_pkg::CFN_W-1:0] meas_frame_skew,
  output logic [toa_pkg::CHIP_W-1:0] chip_remainder
);
  import toa_pkg::*;

  typedef struct packed {
    logic setup_valid;
    logic signed [TOA_W-1:0] win_start;
    logic signed [TOA_W-1:0] win_end;
    logic dl_valid;
    dl_kind_e dl_kind;
    logic [CFN_W-1:0] dl_cfn;
    logic ho_valid;
    logic [CFN_W-1:0] ho_frame;
    logic [CHIP_W-1:0] ho_chip;
    logic peer_held;
    logic signed [TOA_W-1:0] peer_toa;
    logic rep_valid;
    logic rep_kind;
    logic [CFN_W-1:0] rep_cfn;
    logic signed [TOA_W-1:0] rep_toa;
    logic adj_valid;
    logic adj_advance;
    logic signed [TOA_W-1:0] adj_amount;
    logic meas_valid;
    logic [CFN_W-1:0] meas_skew;
    logic [CHIP_W-1:0] meas_rem;
  } ctl_state_s;

  ctl_state_s state_reg;
  ctl_state_s state_next;

  // Next-state logic for requests and reply handling
  always_comb begin
    logic signed [TOA_W-1:0] own;
    logic signed [TOA_W-1:0] low;
    logic [CHIP_W-1:0] nom_chip;
    logic [CFN_W-1:0] nom_frame;
    own = link.ul_toa;
    low = TOA_ZERO;
    nom_chip = CHIP_ZERO;
    nom_frame = CFN_ZERO;
    state_next = state_reg;
    state_next.setup_valid = 1'b0;
    state_next.dl_valid = 1'b0;
    state_next.ho_valid = 1'b0;
    state_next.rep_valid = 1'b0;
    state_next.adj_valid = 1'b0;
    state_next.meas_valid = 1'b0;

    if (setup_req) begin
      state_next.setup_valid = 1'b1;
      state_next.win_start = setup_window_start;
      state_next.win_end = setup_window_end;
    end
    // sync names target frame; sync wins over data
    if (sync_req || data_req) begin
      state_next.dl_valid = 1'b1;
      state_next.dl_kind = sync_req ? DL_SYNC : DL_DATA;
      state_next.dl_cfn = req_cfn;
    end
    if (ho_req) begin
      state_next.ho_valid = 1'b1;
      if (first_link) begin
        state_next.ho_frame = CFN_ZERO;
        state_next.ho_chip = default_dedicated_channel_skew;
      end else begin
        state_next.ho_frame = ho_frame;
        state_next.ho_chip = ho_chip;
      end
    end

    if (peer_toa_valid) begin
      state_next.peer_held = 1'b1;
      state_next.peer_toa = peer_toa;
    end
    if (link.ul_valid) begin
      state_next.rep_valid = 1'b1;
      state_next.rep_kind = link.ul_kind;
      state_next.rep_cfn = link.ul_cfn;
      state_next.rep_toa = link.ul_toa;
      if (state_reg.peer_held) begin
        low = (own < state_reg.peer_toa) ? own : state_reg.peer_toa;
        if (low < 0) begin
          state_next.adj_valid = 1'b1;
          state_next.adj_advance = 1'b1;
          state_next.adj_amount = low;
        end else if (low > 0) begin
          state_next.adj_valid = 1'b1;
          state_next.adj_advance = 1'b0;
          state_next.adj_amount = low;
        end
        state_next.peer_held = peer_toa_valid;
      end
    end

    if (int'(meas_tx_chip) >= NOMINAL_LEAD_CHIPS) begin
      nom_chip = CHIP_W'(int'(meas_tx_chip) - NOMINAL_LEAD_CHIPS);
      nom_frame = meas_tx_frame;
    end else begin
      nom_chip = CHIP_W'(int'(meas_tx_chip) + FRAME_CHIPS - NOMINAL_LEAD_CHIPS);
      nom_frame = meas_tx_frame - 1'b1;
    end
    if (meas_valid) begin
      state_next.meas_valid = 1'b1;
      state_next.meas_rem = (nom_chip == CHIP_ZERO) ? CHIP_ZERO : CHIP_W'(FRAME_CHIPS - int'(nom_chip));
      state_next.meas_skew = meas_target_frame - nom_frame - CFN_W'(nom_chip != CHIP_ZERO);
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{setup_valid: 1'b0, win_start: TOA_ZERO, win_end: TOA_ZERO, dl_valid: 1'b0,
                     dl_kind: DL_DATA, dl_cfn: CFN_ZERO, ho_valid: 1'b0, ho_frame: CFN_ZERO,
                     ho_chip: CHIP_ZERO, peer_held: 1'b0, peer_toa: TOA_ZERO, rep_valid: 1'b0,
                     rep_kind: 1'b0, rep_cfn: CFN_ZERO, rep_toa: TOA_ZERO, adj_valid: 1'b0,
                     adj_advance: 1'b0, adj_amount: TOA_ZERO, meas_valid: 1'b0,
                     meas_skew: CFN_ZERO, meas_rem: CHIP_ZERO};
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.setup_valid = state_reg.setup_valid;
  assign link.window_start_offset = state_reg.win_start;
  assign link.window_end_offset = state_reg.win_end;
  assign link.dl_valid = state_reg.dl_valid;
  assign link.dl_kind = state_reg.dl_kind;
  assign link.dl_cfn = state_reg.dl_cfn;
  assign link.ho_valid = state_reg.ho_valid;
  assign link.ho_frame_offset = state_reg.ho_frame;
  assign link.ho_chip_offset = state_reg.ho_chip;
  assign reply_valid = state_reg.rep_valid;
  assign reply_kind = state_reg.rep_kind;
  assign reply_cfn = state_reg.rep_cfn;
  assign reply_toa = state_reg.rep_toa;
  assign adjust_valid = state_reg.adj_valid;
  assign adjust_advance = state_reg.adj_advance;
  assign adjust_amount = state_reg.adj_amount;
  assign meas_out_valid = state_reg.meas_valid;
  assign meas_frame_skew = state_reg.meas_skew;
  assign chip_remainder = state_reg.meas_rem;
endmodule

// ---- design/toa_link_if.sv ----
// Frame protocol link between controller and base station
`timescale 1ns/10ps
interface toa_link_if;
  import toa_pkg::*;
  logic setup_valid;
  logic signed [TOA_W-1:0] window_start_offset;
  logic signed [TOA_W-1:0] window_end_offset;
  logic dl_valid;
  dl_kind_e dl_kind;
  logic [CFN_W-1:0] dl_cfn;
  logic ho_valid;
  logic [CFN_W-1:0] ho_frame_offset;
  logic [CHIP_W-1:0] ho_chip_offset;
  logic ul_valid;
  ul_kind_e ul_kind;
  logic [CFN_W-1:0] ul_cfn;
  logic signed [TOA_W-1:0] ul_toa;
  modport device (
    input setup_valid, window_start_offset, window_end_offset, dl_valid, dl_kind, dl_cfn,
    input ho_valid, ho_frame_offset, ho_chip_offset,
    output ul_valid, ul_kind, ul_cfn, ul_toa
  );
  modport ctrl (
    output setup_valid, window_start_offset, window_end_offset, dl_valid, dl_kind, dl_cfn,
    output ho_valid, ho_frame_offset, ho_chip_offset,
    input ul_valid, ul_kind, ul_cfn, ul_toa
  );
endinterface

// ---- design/toa_pkg.sv ----
// Shared constants and types for the arrival-window monitor link
package toa_pkg;
  localparam int CFN_W = 8;
  localparam int CHIP_W = 16;
  localparam int ABS_W = 24;
  localparam int TOA_W = 25;
  localparam int FRAME_CHIPS = 38400;
  localparam int FRAME_SPAN = 256;
  localparam int SPAN_CHIPS = FRAME_SPAN * FRAME_CHIPS;
  localparam int HALF_SPAN = SPAN_CHIPS / 2;
  localparam int ROUND_STEP = 256;
  localparam int ROUND_HALF = ROUND_STEP / 2;
  localparam int SLOT_CHIPS = 2560;
  localparam int BURST_CHIPS = SLOT_CHIPS / 10;
  localparam int CELL_COUNT = 3;
  localparam int CELL_SKEW_CHIPS = 2 * BURST_CHIPS;
  localparam int LATEST_LEAD_CHIPS = 1280;
  localparam int CHIP_DIV = 10;
  localparam int DIV_W = 4;
  localparam int NOMINAL_LEAD_CHIPS = 1024;
  localparam logic [CHIP_W-1:0] CHIP_ZERO = 16'h0000;
  localparam logic [CFN_W-1:0] CFN_ZERO = 8'h00;
  localparam logic [TOA_W-1:0] TOA_ZERO = 25'h0000000;
  localparam logic [ABS_W-1:0] ABS_ZERO = 24'h000000;
  typedef enum logic {DL_DATA = 1'b0, DL_SYNC = 1'b1} dl_kind_e;
  typedef enum logic {UL_TIMING_ADJ = 1'b0, UL_SYNC_REPLY = 1'b1} ul_kind_e;
endpackage
